// File: efe_pkg.sv
// Package of constants and types for the Ethernet frame encapsulation block
package efe_pkg;
    // ------------------------------------------------------------------
    // Framing constants
    // ------------------------------------------------------------------
    localparam logic [7:0] PREAMBLE_BYTE = 8'h55;  // Fixed preamble pattern
    localparam logic [7:0] SFD_BYTE      = 8'hD5;  // Start-of-frame delimiter
    localparam int         PREAMBLE_LEN  = 7;      // Preamble bytes per frame
    localparam int         ADDR_LEN      = 6;      // Octets in one MAC address
    localparam int         STD_MAX_FRAME = 1518;   // Untagged limit without preamble
    localparam int         VLAN_EXTRA    = 4;      // Extra bytes allowed for a tag
    localparam logic [15:0] TYPE_VLAN    = 16'h8100; // Tagged frame type
    localparam logic [15:0] TYPE_PAUSE   = 16'h8808; // MAC control frame type
    localparam int         LT_HI_IDX     = 12;     // Byte index of length/type high octet
    localparam int         LT_LO_IDX     = 13;     // Byte index of length/type low octet
    localparam int         CNT_W         = 16;     // Width of byte counters

    // ------------------------------------------------------------------
    // Transmit states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EFE_TX_IDLE = 2'b00,
        EFE_TX_PRE  = 2'b01,
        EFE_TX_SFD  = 2'b10,
        EFE_TX_DATA = 2'b11
    } efe_tx_state_t;

    // ------------------------------------------------------------------
    // Receive states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EFE_RX_HUNT = 2'b00,
        EFE_RX_PRE  = 2'b01,
        EFE_RX_DATA = 2'b10,
        EFE_RX_DROP = 2'b11
    } efe_rx_state_t;
endpackage : efe_pkg

// File: efe_cls_if.sv
// Interface carrying receive frame classification between modules
`timescale 1ns/1ps
interface efe_cls_if;
    logic       byte_vld;   // One received frame byte this cycle
    logic       first;      // Byte is the first of the frame
    logic [7:0] data;       // Frame byte
    logic       group;      // Destination is a group address
    logic       bcast;      // Destination is all ones
    logic       vlan;       // Frame carries a VLAN tag
    logic       pause;      // Frame is a PAUSE control frame
    logic       oversize;   // Frame exceeds limits (informative only)

    modport src (output byte_vld, output first, output data,
                 input group, input bcast, input vlan, input pause, input oversize);
    modport cls (input byte_vld, input first, input data,
                 output group, output bcast, output vlan, output pause, output oversize);
endinterface : efe_cls_if

// File: efe_classifier.sv
// Address and type classifier for received frames
`timescale 1ns/1ps
module efe_classifier #(
    parameter int JUMBO_EN = 1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Frame bytes in, classes out
    efe_cls_if.cls    cls
);
    // ------------------------------------------------------------------
    // Byte position and accumulated classes
    // ------------------------------------------------------------------
    logic [efe_pkg::CNT_W-1:0] idx_ff;     // Index of the next byte
    logic                      group_ff;   // I/G bit of destination
    logic                      bcast_ff;   // All destination octets 0xFF so far
    logic [7:0]                lt_hi_ff;   // Length/type high octet
    logic                      vlan_ff;    // Tag seen
    logic                      pause_ff;   // PAUSE type seen
    logic                      over_ff;    // Size beyond untagged or tagged limit
    logic [efe_pkg::CNT_W-1:0] cur_idx;    // Index of byte on the input now
    logic [efe_pkg::CNT_W-1:0] limit;      // Size limit for this frame

    assign cur_idx = cls.first ? '0 : idx_ff;
    // Tagged frames get four more bytes of room
    assign limit = vlan_ff ? efe_pkg::CNT_W'(efe_pkg::STD_MAX_FRAME + efe_pkg::VLAN_EXTRA)
                           : efe_pkg::CNT_W'(efe_pkg::STD_MAX_FRAME); // see [RQ9]

    // Byte index, saturates rather than wrapping on jumbo frames
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            idx_ff <= '0;
        else if (cls.byte_vld && cur_idx != '1)
            idx_ff <= cur_idx + 1'b1;
    end

    // Destination classes: I/G is bit zero of the first octet
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            group_ff <= 1'b0;
            bcast_ff <= 1'b0;
        end
        else if (cls.byte_vld && cur_idx < efe_pkg::ADDR_LEN)
        begin
            if (cur_idx == '0)
                group_ff <= cls.data[0]; // see [RQ11]
            bcast_ff <= (cur_idx == '0 || bcast_ff) && cls.data == 8'hFF; // see [RQ12]
        end
    end

    // Length/type decode for tagged and PAUSE frames
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lt_hi_ff <= 8'h00;
            vlan_ff  <= 1'b0;
            pause_ff <= 1'b0;
        end
        else if (cls.byte_vld)
        begin
            if (cur_idx == '0)
            begin
                vlan_ff  <= 1'b0;
                pause_ff <= 1'b0;
            end
            if (cur_idx == efe_pkg::LT_HI_IDX)
                lt_hi_ff <= cls.data;
            if (cur_idx == efe_pkg::LT_LO_IDX)
            begin
                vlan_ff  <= {lt_hi_ff, cls.data} == efe_pkg::TYPE_VLAN;
                pause_ff <= {lt_hi_ff, cls.data} == efe_pkg::TYPE_PAUSE; // see [RQ10]
            end
        end
    end

    // Oversize flag; jumbo support holds the output low, never an error
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            over_ff <= 1'b0;
        else if (cls.byte_vld)
            over_ff <= (cur_idx == '0) ? 1'b0 : (over_ff || cur_idx >= limit);
    end

    assign cls.group    = group_ff;
    assign cls.bcast    = bcast_ff;
    assign cls.vlan     = vlan_ff;
    assign cls.pause    = pause_ff;
    assign cls.oversize = (JUMBO_EN == 0) && over_ff; // see [RQ8]
endmodule : efe_classifier

// File: efe_encap.sv
// Ethernet frame encapsulation: preamble/SFD insertion on transmit, stripping on receive
//
// Operation
// [RQ1] Transmit prepends seven 0x55 preamble bytes
// [RQ2] Receive strips preamble before client delivery
// [RQ3] Custom preamble mode sends client-supplied bytes
// [RQ4] Transmit inserts SFD after preamble
// [RQ5] Receive discards SFD before client delivery
// [RQ6] SFD value is 0xD5, LSB first
// [RQ7] Fields in order, bytes LSB first
// [RQ8] Jumbo frames pass without error
// [RQ9] Tagged frames allowed four extra bytes
// [RQ10] PAUSE frames sent and received
// [RQ11] Address bit zero: individual or group
// [RQ12] All-ones destination is broadcast
// [RQ13] Addresses sent LSB first, I/G first
// [RQ14] Destination address stays first field
// [RQ15] Client supplies source address, passed unchanged
// [RQ16] MAC and MAC control in all modes
// [RQ17] Client registers all MAC inputs/outputs
`timescale 1ns/1ps
module efe_encap #(
    parameter int JUMBO_EN = 1
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Mode
    input  wire logic       custom_pre_en,
    input  wire logic [55:0] custom_pre,
    // Client transmit byte stream
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // Line transmit byte stream
    output logic [7:0]      line_tx_data,
    output logic            line_tx_en,
    // Line receive byte stream
    input  wire logic [7:0] line_rx_data,
    input  wire logic       line_rx_dv,
    // Client receive byte stream
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_first,
    output logic            rx_last,
    // Receive classification of the last delivered frame
    output logic            rx_group,
    output logic            rx_bcast,
    output logic            rx_vlan,
    output logic            rx_pause,
    output logic            rx_oversize
);
    // ------------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------------
    efe_pkg::efe_tx_state_t tx_st_ff;       // Transmit state
    logic [2:0]             pre_cnt_ff;     // Preamble byte index
    logic [55:0]            pre_sh_ff;      // Preamble bytes still to send
    logic                   tx_done_ff;     // Frame end passed, one gap cycle

    // Client bytes are only taken in the data phase, so header bytes
    // (destination first, then source) go out unchanged and in order.
    assign tx_ready = (tx_st_ff == efe_pkg::EFE_TX_DATA); // see [RQ14]

    // Transmit sequencer: preamble, SFD, then client bytes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_st_ff   <= efe_pkg::EFE_TX_IDLE;
            pre_cnt_ff <= 3'h0;
            pre_sh_ff  <= '0;
            tx_done_ff <= 1'b0;
        end
        else
        begin
            tx_done_ff <= 1'b0;
            unique case (tx_st_ff)
                efe_pkg::EFE_TX_IDLE:
                begin
                    // A waiting frame starts its preamble; at least two idle cycles follow each frame
                    if (tx_valid && !tx_done_ff)
                    begin
                        tx_st_ff   <= efe_pkg::EFE_TX_PRE;
                        pre_cnt_ff <= 3'h0;
                        // Custom mode replaces the fixed pattern in the same slots
                        pre_sh_ff  <= custom_pre_en ? custom_pre
                                                    : {efe_pkg::PREAMBLE_LEN{efe_pkg::PREAMBLE_BYTE}}; // see [RQ1] [RQ3]
                    end
                end
                efe_pkg::EFE_TX_PRE:
                begin
                    pre_sh_ff  <= {8'h00, pre_sh_ff[55:8]};
                    pre_cnt_ff <= pre_cnt_ff + 3'h1;
                    if (pre_cnt_ff == 3'(efe_pkg::PREAMBLE_LEN - 1))
                        tx_st_ff <= efe_pkg::EFE_TX_SFD; // see [RQ4]
                end
                efe_pkg::EFE_TX_SFD:
                    tx_st_ff <= efe_pkg::EFE_TX_DATA;
                efe_pkg::EFE_TX_DATA:
                begin
                    // Client is trusted to keep valid high through the frame
                    if (tx_valid && tx_last)
                    begin
                        tx_st_ff   <= efe_pkg::EFE_TX_IDLE;
                        tx_done_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Line transmit register: bytes leave whole; the PHY serialises LSB first
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            line_tx_data <= 8'h00;
            line_tx_en   <= 1'b0;
        end
        else
        begin
            unique case (tx_st_ff)
                efe_pkg::EFE_TX_PRE:
                begin
                    line_tx_data <= pre_sh_ff[7:0];
                    line_tx_en   <= 1'b1;
                end
                efe_pkg::EFE_TX_SFD:
                begin
                    line_tx_data <= efe_pkg::SFD_BYTE; // see [RQ6]
                    line_tx_en   <= 1'b1;
                end
                efe_pkg::EFE_TX_DATA:
                begin
                    // Bit 0 of each byte is first on the wire, so the I/G bit leads
                    line_tx_data <= tx_data; // see [RQ7] [RQ13]
                    line_tx_en   <= tx_valid;
                end
                default:
                begin
                    line_tx_data <= 8'h00;
                    line_tx_en   <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------
    efe_pkg::efe_rx_state_t rx_st_ff;       // Receive state
    logic [7:0]             hold_data_ff;   // Byte held back to find the last one
    logic                   hold_vld_ff;    // Held byte present
    logic                   hold_first_ff;  // Held byte is frame start
    logic                   first_pend_ff;  // Next data byte is frame start
    logic                   take;           // Frame byte accepted this cycle
    efe_cls_if              cls_if ();      // Link to classifier

    assign take = (rx_st_ff == efe_pkg::EFE_RX_DATA) && line_rx_dv;

    // Receive sequencer: hunt preamble, drop through SFD, pass the rest
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rx_st_ff <= efe_pkg::EFE_RX_HUNT;
        else
        begin
            unique case (rx_st_ff)
                efe_pkg::EFE_RX_HUNT:
                    if (line_rx_dv)
                        rx_st_ff <= efe_pkg::EFE_RX_PRE;
                efe_pkg::EFE_RX_PRE:
                begin
                    // Preamble (or custom content free of 0xD5) is never delivered
                    if (!line_rx_dv)
                        rx_st_ff <= efe_pkg::EFE_RX_HUNT; // see [RQ2]
                    else if (line_rx_data == efe_pkg::SFD_BYTE)
                        rx_st_ff <= efe_pkg::EFE_RX_DATA; // see [RQ5]
                end
                efe_pkg::EFE_RX_DATA:
                    if (!line_rx_dv)
                        rx_st_ff <= efe_pkg::EFE_RX_HUNT;
                efe_pkg::EFE_RX_DROP:
                    rx_st_ff <= efe_pkg::EFE_RX_HUNT;
            endcase
        end
    end

    // One-byte hold so the final byte can be flagged last when DV drops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_data_ff  <= 8'h00;
            hold_vld_ff   <= 1'b0;
            hold_first_ff <= 1'b0;
            first_pend_ff <= 1'b0;
        end
        else
        begin
            if (rx_st_ff == efe_pkg::EFE_RX_PRE)
                first_pend_ff <= 1'b1;
            else if (take)
                first_pend_ff <= 1'b0;
            if (take)
            begin
                hold_data_ff  <= line_rx_data;
                hold_first_ff <= first_pend_ff;
            end
            hold_vld_ff <= take;
        end
    end

    // Client receive register: destination stays first, nothing rewritten
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
            rx_first <= 1'b0;
            rx_last  <= 1'b0;
        end
        else
        begin
            rx_valid <= hold_vld_ff;
            rx_data  <= hold_vld_ff ? hold_data_ff : 8'h00; // see [RQ14]
            rx_first <= hold_vld_ff && hold_first_ff;
            rx_last  <= hold_vld_ff && !take;
        end
    end

    // Classification: PAUSE, tag, group and broadcast, all modes alike
    assign cls_if.byte_vld = take;
    assign cls_if.first    = take && first_pend_ff;
    assign cls_if.data     = line_rx_data;

    efe_classifier #(
        .JUMBO_EN (JUMBO_EN)
    ) u_cls (
        .clk  (clk),
        .rstn (rstn),
        .cls  (cls_if.cls)
    ); // see [RQ16]

    assign rx_group    = cls_if.group;
    assign rx_bcast    = cls_if.bcast;
    assign rx_vlan     = cls_if.vlan;
    assign rx_pause    = cls_if.pause;
    assign rx_oversize = cls_if.oversize;
endmodule : efe_encap

// File: efe_encap_properties.sv
// Port-level checker of the encapsulation block
`timescale 1ns/1ps
module efe_encap_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Client transmit
    input wire logic       custom_pre_en,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_last,
    input wire logic       tx_ready,
    // Line side
    input wire logic [7:0] line_tx_data,
    input wire logic       line_tx_en,
    input wire logic [7:0] line_rx_data,
    input wire logic       line_rx_dv,
    // Client receive
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_last,
    input wire logic       rx_vlan,
    input wire logic       rx_pause
);
    // -----------------------------------------------------------------
    // Properties, all in the single clock domain
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_pre;
        $rose(line_tx_en) && !custom_pre_en |-> (line_tx_data == efe_pkg::PREAMBLE_BYTE) [*7]
            ##1 line_tx_data == efe_pkg::SFD_BYTE;
    endproperty
    a_pre: assert property (p_pre) else $error("preamble or delimiter wrong");
    property p_hold;
        $rose(line_tx_en) |-> !tx_ready [*7];
    endproperty
    a_hold: assert property (p_hold) else $error("byte taken in preamble");
    property p_pass;
        tx_valid && tx_ready |=> line_tx_en && line_tx_data == $past(tx_data);
    endproperty
    a_pass: assert property (p_pass) else $error("client byte not next on line");
    property p_end;
        tx_valid && tx_ready && tx_last |=> ##1 !line_tx_en;
    endproperty
    a_end: assert property (p_end) else $error("line frame end wrong");
    property p_refr;
        tx_valid && tx_ready && tx_last |=> !tx_ready [*8];
    endproperty
    a_refr: assert property (p_refr) else $error("next frame skipped preamble");
    property p_strip;
        $rose(line_rx_dv) |=> !rx_valid [*8];
    endproperty
    a_strip: assert property (p_strip) else $error("preamble delivered");
    property p_pipe;
        rx_valid |-> rx_data == $past(line_rx_data, 2) && $past(line_rx_dv, 2);
    endproperty
    a_pipe: assert property (p_pipe) else $error("delivered byte wrong");
    property p_last;
        rx_valid && rx_last |-> $past(line_rx_dv, 2) && !$past(line_rx_dv);
    endproperty
    a_last: assert property (p_last) else $error("last flag wrong");
    c_cust: cover property ($rose(line_tx_en) && custom_pre_en);
    c_vlan: cover property (rx_valid && rx_last && rx_vlan);
    c_pause: cover property (rx_valid && rx_last && rx_pause);
endmodule : efe_encap_properties

// File: efe_phy_model.sv
// Line partner: loops each transmitted frame back onto the receive pins
`timescale 1ns/1ps
module efe_phy_model (
    // Clock
    input wire logic       clk,
    // Transmit pins and bench commands
    input wire logic [7:0] line_tx_data,
    input wire logic       line_tx_en,
    input wire logic       trunc,
    input wire logic [3:0] gap,
    // Receive pins and status
    output logic [7:0]     line_rx_data,
    output logic           line_rx_dv,
    output logic           busy
);
    logic [7:0] cap[$];  // Frame now on the transmit pins
    logic [7:0] pend[$]; // Finished frames, end to end
    int         lens[$]; // Length of each finished frame
    int         n;
    int         j;
    // A low enable closes a frame, so frames never merge
    always @(posedge clk)
        if (line_tx_en)
            cap.push_back(line_tx_data);
        else if (cap.size() != 0)
        begin
            pend = {pend, cap};
            lens.push_back(cap.size());
            cap.delete();
        end
    // Replay just after each edge, as from a flop; idle data toggles
    initial
    begin
        line_rx_dv = 1'b0;
        line_rx_data = 8'hA5;
        busy = 1'b0;
        forever
        begin
            @(posedge clk);
            #1;
            busy = cap.size() != 0 || lens.size() != 0;
            if (lens.size() == 0)
                line_rx_data = ~line_rx_data;
            else
            begin
                n = lens.pop_front();
                for (j = 0; j < n; j++)
                begin
                    line_rx_data = pend.pop_front();
                    line_rx_dv = !trunc || j < 4; // Cut frames die in the preamble
                    @(posedge clk);
                    #1;
                end
                // Released data shows the inverse; dv stays low for gap more cycles
                line_rx_dv = 1'b0;
                line_rx_data = ~line_rx_data;
                repeat (gap) @(posedge clk);
            end
        end
    end
endmodule : efe_phy_model

// File: test_efe_encap.sv
// Self-checking bench of the encapsulation block
`timescale 1ns/1ps
module test_efe_encap;
    // -----------------------------------------------------------------
    // Signals and expectations
    // -----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        custom_pre_en = 1'b0;
    logic [55:0] custom_pre = 56'h0;
    logic [7:0]  tx_data = 8'h00;
    logic        tx_valid = 1'b0;
    logic        tx_last = 1'b0;
    logic        trunc = 1'b0;  // Line model cuts frames short
    logic [3:0]  gap = 4'h1;
    logic [7:0]  line_tx_data, line_rx_data, rx_data;
    logic        tx_ready, line_tx_en, line_rx_dv, rx_valid, rx_first, rx_last, busy;
    logic        rx_group, rx_bcast, rx_vlan, rx_pause, rx_oversize;
    logic [14:0] got_rx;        // Byte, flags, and classes on the last byte
    logic [7:0]  exp_line[$];   // Bytes due on the line
    logic [14:0] exp_rx[$];     // Bytes due at the client
    logic [47:0] da;
    logic [15:0] lt;
    int          bad_count = 0;
    int          n_tests = 0;
    int          seed = 32'hfbd8;
    int          k;
    assign got_rx = {rx_first, rx_last, rx_data,
        rx_last ? {rx_group, rx_bcast, rx_vlan, rx_pause, rx_oversize} : 5'h00};
    efe_encap #(.JUMBO_EN(1)) i_efe_encap (
        .clk (clk), .rstn (rstn), .custom_pre_en (custom_pre_en), .custom_pre (custom_pre),
        .tx_data (tx_data), .tx_valid (tx_valid), .tx_last (tx_last), .tx_ready (tx_ready),
        .line_tx_data (line_tx_data), .line_tx_en (line_tx_en),
        .line_rx_data (line_rx_data), .line_rx_dv (line_rx_dv),
        .rx_data (rx_data), .rx_valid (rx_valid), .rx_first (rx_first), .rx_last (rx_last),
        .rx_group (rx_group), .rx_bcast (rx_bcast), .rx_vlan (rx_vlan), .rx_pause (rx_pause),
        .rx_oversize (rx_oversize));
    efe_phy_model i_efe_phy_model (.clk(clk), .line_tx_data(line_tx_data),
        .line_tx_en(line_tx_en), .trunc(trunc), .gap(gap),
        .line_rx_data(line_rx_data), .line_rx_dv(line_rx_dv), .busy(busy));
    initial
        forever #4 clk = ~clk;
    task automatic chk_line(input logic [7:0] got, input logic [7:0] want);
        n_tests++;
        if (got !== want)
        begin
            bad_count++;
            $display("BAD %0t line %h want %h", $time, got, want);
        end
    endtask : chk_line
    task automatic chk_rx(input logic [14:0] got, input logic [14:0] want);
        n_tests++;
        if (got !== want)
        begin
            bad_count++;
            $display("BAD %0t client %h want %h", $time, got, want);
        end
    endtask : chk_rx
    // Score every byte where it stands
    always @(posedge clk)
    begin
        if (line_tx_en)
            chk_line(line_tx_data, exp_line.pop_front());
        if (rx_valid)
            chk_rx(got_rx, exp_rx.pop_front());
    end
    // One frame; inputs change just after an edge, as from a flop
    task automatic send(input int len, input logic cust);
        logic [7:0] p[$];
        logic [7:0] b;
        logic [4:0] cls;
        int i;
        int w;
        custom_pre = 56'({$random(seed), $random(seed)}) | {7{8'h02}}; // Keeps D5 out
        for (i = 0; i < 7; i++)
            exp_line.push_back(cust ? custom_pre[8*i +: 8] : 8'h55);
        exp_line.push_back(8'hD5);
        cls = {da[0], &da, lt == 16'h8100, lt == 16'h8808, 1'b0};
        for (i = 0; i < len; i++)
        begin
            b = i < 6 ? da[8*i +: 8] : 8'($random(seed)); // Random source
            if (i == 12 || i == 13)
                b = i == 12 ? lt[15:8] : lt[7:0];
            p.push_back(b);
            exp_line.push_back(b);
            if (!trunc)
                exp_rx.push_back({i == 0, i == len - 1, b, i == len - 1 ? cls : 5'h00});
        end
        custom_pre_en = cust;
        tx_valid = 1'b1;
        i = 0;
        for (w = 0; i < len && w < 9000; w++)
        begin
            tx_data = p[i];
            tx_last = i == len - 1;
            @(posedge clk);
            if (tx_ready === 1'b1)
                i++;
            #1;
        end
        tx_valid = 1'b0;
        tx_last = 1'b0;
        @(posedge clk);
        #1;
    endtask : send
    task automatic drain;
        int w;
        for (w = 0; w < 9000 && (busy || exp_rx.size() || exp_line.size()); w++)
            @(posedge clk);
        #1;
    endtask : drain
    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    // -----------------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        @(posedge clk);
        #1;
        // Unicast, group, broadcast, tagged, control, jumbo, back to back
        for (k = 0; k < 12; k++)
        begin
            gap = 4'($random(seed));
            da = {16'($random(seed)), 32'($random(seed))};
            da[0] = k % 3 == 1;
            if (k % 3 == 2)
                da = '1;
            lt = k == 3 ? 16'h8100 : k == 4 ? 16'h8808 : 16'h0800;
            send(k == 5 ? 1600 : k == 3 ? 1522 : 60 + k, k[0]);
        end
        drain;
        trunc = 1'b1;
        send(60, 1'b0);
        drain;
        trunc = 1'b0;
        send(61, 1'b1);
        drain;
        chk_line(8'(exp_line.size() + exp_rx.size()), 8'h00);
        end_sim;
    end
    initial
    begin
        #400000;
        bad_count++;
        $display("BAD %0t timeout", $time);
        end_sim;
    end
endmodule : test_efe_encap
bind efe_encap efe_encap_properties i_efe_encap_properties (
    .clk (clk), .rstn (rstn), .custom_pre_en (custom_pre_en),
    .tx_data (tx_data), .tx_valid (tx_valid), .tx_last (tx_last), .tx_ready (tx_ready),
    .line_tx_data (line_tx_data), .line_tx_en (line_tx_en),
    .line_rx_data (line_rx_data), .line_rx_dv (line_rx_dv),
    .rx_data (rx_data), .rx_valid (rx_valid), .rx_last (rx_last),
    .rx_vlan (rx_vlan), .rx_pause (rx_pause));
